// file: shared/hrf_pkg.sv
/*
 * Constants for the host request frame decoder: framing bytes, frame type
 * codes, field offsets, minimum lengths, parameter names and reset values.
 * Assumes byte offsets count from the start delimiter at offset 0.
 */
package hrf_pkg;

    // Framing bytes
    localparam logic [7:0] DELIM = 8'h7e;
    localparam logic [7:0] ESC_MARK = 8'h7d;
    localparam logic [7:0] ESC_XOR = 8'h20;
    localparam logic [7:0] CSUM_OK = 8'hff;

    // Frame type codes, requests and answers
    localparam logic [7:0] T_LEGACY_TX = 8'h00;
    localparam logic [7:0] T_PARAM_NOW = 8'h08;
    localparam logic [7:0] T_PARAM_QUEUE = 8'h09;
    localparam logic [7:0] T_TX = 8'h10;
    localparam logic [7:0] T_TX_STATUS = 8'h8b;
    localparam logic [7:0] T_PARAM_RESP = 8'h88;
    localparam logic [7:0] T_NONE = 8'hff;

    // Field offsets within the frame
    localparam logic [16:0] OFF_TYPE = 17'd3;
    localparam logic [16:0] OFF_ID = 17'd4;
    localparam logic [16:0] OFF_DEST_FIRST = 17'd5;
    localparam logic [16:0] OFF_DEST_LAST = 17'd12;
    localparam logic [16:0] OFF_LEG_OPT = 17'd13;
    localparam logic [16:0] OFF_LEG_PAY = 17'd14;
    localparam logic [16:0] OFF_HOPS = 17'd15;
    localparam logic [16:0] OFF_TX_OPT = 17'd16;
    localparam logic [16:0] OFF_TX_PAY = 17'd17;
    localparam logic [16:0] OFF_CMD_FIRST = 17'd5;
    localparam logic [16:0] OFF_CMD_LAST = 17'd6;
    localparam logic [16:0] OFF_VALUE = 17'd7;
    localparam logic [16:0] OFF_END_ADJ = 17'd2;

    // Least frame data length for each request type
    localparam logic [15:0] MIN_LEN_LEGACY = 16'd11;
    localparam logic [15:0] MIN_LEN_TX = 16'd14;
    localparam logic [15:0] MIN_LEN_PARAM = 16'd4;

    localparam logic [63:0] BCAST_ADDR = 64'h0000_0000_0000_ffff;
    localparam logic [7:0] LEG_OPT_NO_ACK = 8'h01;
    localparam logic [15:0] MAX_PAYLOAD = 16'd256;
    localparam logic [15:0] PAY_CNT_ONE = 16'd1;

    // Two-character parameter names
    localparam logic [15:0] NAME_APPLY = 16'h4143;
    localparam logic [15:0] NAME_MAX_PAY = 16'h4e50;
    localparam int N_PAR = 3;
    localparam int PAR_RATE = 0;
    localparam int PAR_HOPS = 1;
    localparam int PAR_ESC = 2;
    localparam logic [15:0] PAR_NAME [N_PAR] = '{16'h4244, 16'h4e48, 16'h4150};
    localparam logic [7:0] PAR_RST [N_PAR] = '{8'h03, 8'h07, 8'h01};
    localparam logic [7:0] ESC_ON = 8'h02;

    // Payload stream width: one data byte
    localparam int PAY_W = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LEN_HI,
        ST_LEN_LO,
        ST_DATA,
        ST_CSUM
    } hrf_state_e;

endpackage : hrf_pkg

// file: shared/hrf_stream_if.sv
/*
 * Byte stream with last marker and valid/ready handshake.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface hrf_stream_if;
    logic [hrf_pkg::PAY_W-1:0] data;
    logic last;
    logic valid;
    logic ready;

    // Producer side
    modport src (output data, output last, output valid, input ready);
    // Consumer side
    modport snk (input data, input last, input valid, output ready);
endinterface : hrf_stream_if

`default_nettype wire

// file: rtl/hrf_skid_buf.sv
/*
 * Two-entry buffer on the payload path; valid and ready on both sides,
 * both registered. Assumes a single clock and synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module hrf_skid_buf (
    input wire logic clk,
    input wire logic sys_rst,
    hrf_stream_if.snk up,
    hrf_stream_if.src dn
);
    localparam int W = hrf_pkg::PAY_W + 1;
    localparam logic [1:0] CNT_FULL = 2'd2;
    localparam logic [1:0] CNT_ONE = 2'd1;
    localparam logic [1:0] CNT_NONE = 2'd0;

    logic [W-1:0] mem_q [2];
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    logic in_ready_q;
    logic out_valid_q;
    wire push = up.valid & in_ready_q;
    wire pop = out_valid_q & dn.ready;
    wire [W-1:0] in_word = {up.last, up.data};
    wire refill = pop & (cnt_q == CNT_FULL);
    wire wr0 = (push & ((cnt_q == CNT_NONE) | ((cnt_q == CNT_ONE) & pop))) | refill;
    wire wr1 = push & (((cnt_q == CNT_ONE) & ~pop) | ((cnt_q == CNT_FULL) & pop));
    wire [W-1:0] wr0_word = refill ? mem_q[1] : in_word;

    // Occupancy after this cycle's push and pop
    assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    assign up.ready = in_ready_q;
    assign dn.valid = out_valid_q;
    assign dn.data = mem_q[0][W-2:0];
    assign dn.last = mem_q[0][W-1];

    // Count and flags
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt_q <= CNT_NONE;
            in_ready_q <= 1'b0;
            out_valid_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            in_ready_q <= (cnt_d != CNT_FULL);
            out_valid_q <= (cnt_d != CNT_NONE);
        end
    end

    // Storage, head in entry 0
    always_ff @(posedge clk)
    begin
        if (wr0)
            mem_q[0] <= wr0_word;
        if (wr1)
            mem_q[1] <= in_word;
    end
endmodule : hrf_skid_buf

`default_nettype wire

// file: rtl/hrf_frame_decoder.sv
/*
 * Host request frame decoder: collects delimited, length-prefixed,
 * checksummed request frames from the serial byte stream, undoes escaping,
 * decodes transmit and parameter requests, streams payload through a
 * two-entry buffer and keeps active and queued parameter values.
 * Assumes rx bytes are synchronous to clk; the consumer of pay_* drops a
 * frame's payload when tx_done pulses with tx_ok low.
 */
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Legacy transmit request type 0x00 sends payload
// - Nonzero frame id gives response, zero none
// - Legacy destination offsets 5-12, FFFF broadcast
// - Legacy option 1 disables acknowledgment
// - Legacy payload from offset 14 to checksum
// - Immediate parameter command applies at once
// - Name then checksum means parameter read
// - Offsets 5 and 6 name the parameter
// - Queued command stores, applies on apply
// - Bytes from offset 7 are write value
// - Old setting stays until queued apply
// - One, two or four value bytes equal
// - Transmit request destination MSB first, broadcast
// - Hop byte zero uses network hop limit
// - Options at 16, payload from 17, capped
// - Max payload query answers byte count
// - Transmit status 0x8B carries frame id
// - Bytes before start delimiter are ignored
// - Length counts frame data bytes only
// - Checksum FF minus sum, bad frames dropped
// - Escaped bytes are 7D then XOR 20
module hrf_frame_decoder (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [7:0] pay_data,
    output logic pay_last,
    output logic pay_valid,
    input wire logic pay_ready,
    output logic tx_done,
    output logic tx_ok,
    output logic tx_legacy,
    output logic [7:0] tx_frame_id,
    output logic [63:0] tx_dest,
    output logic tx_bcast,
    output logic tx_no_ack,
    output logic [7:0] tx_opts,
    output logic [7:0] tx_hops,
    output logic resp_valid,
    output logic [7:0] resp_type,
    output logic [7:0] resp_frame_id,
    output logic [31:0] resp_value,
    output logic frame_err,
    output logic [7:0] serial_rate_setting,
    output logic [7:0] network_hop_limit,
    output logic [7:0] api_escape_setting
);
    hrf_pkg::hrf_state_e state_q;
    hrf_pkg::hrf_state_e state_d;
    logic esc_pend_q;
    logic [15:0] len_q;
    logic [16:0] pos_q;
    logic [7:0] sum_q;
    logic [7:0] type_q;
    logic [7:0] id_q;
    logic [63:0] dest_q;
    logic [7:0] lopt_q;
    logic [7:0] hops_q;
    logic [7:0] txopt_q;
    logic [15:0] cmd_q;
    logic [31:0] val_q;
    logic has_val_q;
    logic [15:0] pay_cnt_q;
    logic over_q;
    logic [7:0] par_act_q [hrf_pkg::N_PAR];
    logic [7:0] par_pend_q [hrf_pkg::N_PAR];
    logic [7:0] par_pend_d [hrf_pkg::N_PAR];
    logic [7:0] par_act_d [hrf_pkg::N_PAR];
    logic [31:0] rd_val;

    hrf_stream_if push_if ();
    hrf_stream_if pop_if ();

    // Payload buffer; its input ready is the serial back-pressure
    hrf_skid_buf u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .up(push_if.snk),
        .dn(pop_if.src)
    );

    assign rx_ready = push_if.ready;
    assign pay_data = pop_if.data;
    assign pay_last = pop_if.last;
    assign pay_valid = pop_if.valid;
    assign pop_if.ready = pay_ready;
    assign serial_rate_setting = par_act_q[hrf_pkg::PAR_RATE];
    assign network_hop_limit = par_act_q[hrf_pkg::PAR_HOPS];
    assign api_escape_setting = par_act_q[hrf_pkg::PAR_ESC];

    // Byte intake, delimiter hunt and unescaping
    wire take = rx_valid & push_if.ready;
    wire esc_on = (par_act_q[hrf_pkg::PAR_ESC] == hrf_pkg::ESC_ON);
    wire idle = (state_q == hrf_pkg::ST_IDLE);
    wire restart = take & (rx_data == hrf_pkg::DELIM) & (idle | esc_on);
    wire esc_mark = take & esc_on & ~idle & ~esc_pend_q & (rx_data == hrf_pkg::ESC_MARK);
    wire vb = take & ~restart & ~esc_mark & ~idle;
    wire [7:0] vbyte = esc_pend_q ? (rx_data ^ hrf_pkg::ESC_XOR) : rx_data;

    // Position and type decode
    wire in_data = (state_q == hrf_pkg::ST_DATA);
    wire fin = vb & (state_q == hrf_pkg::ST_CSUM);
    wire [15:0] len_next = {len_q[15:8], vbyte};
    wire [16:0] pos_end = {1'b0, len_q} + hrf_pkg::OFF_END_ADJ;
    wire at_end = (pos_q == pos_end);
    wire is_leg = (type_q == hrf_pkg::T_LEGACY_TX);
    wire is_tx = (type_q == hrf_pkg::T_TX);
    wire is_now = (type_q == hrf_pkg::T_PARAM_NOW);
    wire is_par = is_now | (type_q == hrf_pkg::T_PARAM_QUEUE);
    wire tx_kind = is_leg | is_tx;
    wire [16:0] pay_start = is_leg ? hrf_pkg::OFF_LEG_PAY : hrf_pkg::OFF_TX_PAY;
    wire past_type = (pos_q > hrf_pkg::OFF_TYPE);

    // Payload forwarding with the length cap
    wire is_pay = vb & in_data & past_type & tx_kind & (pos_q >= pay_start);
    wire pay_full = (pay_cnt_q >= hrf_pkg::MAX_PAYLOAD);
    assign push_if.valid = is_pay & ~pay_full;
    assign push_if.data = vbyte;
    assign push_if.last = at_end;

    // Frame acceptance at the checksum byte
    wire [7:0] sum_fin = sum_q + vbyte;
    wire csum_good = (sum_fin == hrf_pkg::CSUM_OK);
    wire [15:0] min_len = is_leg ? hrf_pkg::MIN_LEN_LEGACY :
                          is_tx ? hrf_pkg::MIN_LEN_TX : hrf_pkg::MIN_LEN_PARAM;
    wire too_short = (len_q < min_len);
    wire known = tx_kind | is_par;
    wire good = fin & csum_good & ~too_short & known;
    wire tx_end = tx_kind & (fin | (restart & ~idle & past_type));

    // Parameter command decode
    wire par_good = good & is_par;
    wire is_apply_cmd = (cmd_q == hrf_pkg::NAME_APPLY);
    wire par_write = par_good & has_val_q & ~is_apply_cmd;
    wire par_apply = par_good & (is_now | is_apply_cmd);
    wire [7:0] new_val = val_q[7:0];

    // Per-parameter queued and active values
    genvar gi;
    generate
        for (gi = 0; gi < hrf_pkg::N_PAR; gi++)
        begin : g_par
            wire hit = (cmd_q == hrf_pkg::PAR_NAME[gi]);
            assign par_pend_d[gi] = (par_write & hit) ? new_val : par_pend_q[gi];
            assign par_act_d[gi] = par_apply ? par_pend_d[gi] : par_act_q[gi];
            always_ff @(posedge clk)
            begin
                if (sys_rst)
                begin
                    par_act_q[gi] <= hrf_pkg::PAR_RST[gi];
                    par_pend_q[gi] <= hrf_pkg::PAR_RST[gi];
                end
                else
                begin
                    par_act_q[gi] <= par_act_d[gi];
                    par_pend_q[gi] <= par_pend_d[gi];
                end
            end
        end
    endgenerate

    // Read-back value for a query
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (cmd_q == hrf_pkg::NAME_MAX_PAY)
            rd_val = {16'h0000, hrf_pkg::MAX_PAYLOAD};
        for (int i = 0; i < hrf_pkg::N_PAR; i++)
        begin
            if (cmd_q == hrf_pkg::PAR_NAME[i])
                rd_val = {24'h00_0000, par_act_q[i]};
        end
    end

    // Frame state sequence
    always_comb
    begin
        state_d = state_q;
        if (restart)
            state_d = hrf_pkg::ST_LEN_HI;
        else if (vb)
        begin
            case (state_q)
                hrf_pkg::ST_LEN_HI: state_d = hrf_pkg::ST_LEN_LO;
                hrf_pkg::ST_LEN_LO:
                    state_d = (len_next == 16'h0000) ? hrf_pkg::ST_CSUM : hrf_pkg::ST_DATA;
                hrf_pkg::ST_DATA:
                    state_d = at_end ? hrf_pkg::ST_CSUM : hrf_pkg::ST_DATA;
                hrf_pkg::ST_CSUM: state_d = hrf_pkg::ST_IDLE;
                default: state_d = hrf_pkg::ST_IDLE;
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q <= hrf_pkg::ST_IDLE;
            esc_pend_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            esc_pend_q <= esc_mark | (esc_pend_q & ~vb & ~restart);
        end
    end

    // Length, position, running sum and payload count
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            len_q <= 16'h0000;
            pos_q <= hrf_pkg::OFF_TYPE;
            sum_q <= 8'h00;
            pay_cnt_q <= 16'h0000;
            over_q <= 1'b0;
        end
        else if (restart)
        begin
            pos_q <= hrf_pkg::OFF_TYPE;
            sum_q <= 8'h00;
            pay_cnt_q <= 16'h0000;
            over_q <= 1'b0;
        end
        else if (vb)
        begin
            if (state_q == hrf_pkg::ST_LEN_HI)
                len_q <= {vbyte, 8'h00};
            if (state_q == hrf_pkg::ST_LEN_LO)
                len_q <= len_next;
            if (in_data)
            begin
                pos_q <= pos_q + 17'd1;
                sum_q <= sum_fin;
            end
            if (is_pay & ~pay_full)
                pay_cnt_q <= pay_cnt_q + hrf_pkg::PAY_CNT_ONE;
            if (is_pay & pay_full)
                over_q <= 1'b1;
        end
    end

    // Field capture by frame offset
    always_ff @(posedge clk)
    begin
        if (sys_rst | restart)
        begin
            type_q <= hrf_pkg::T_NONE;
            has_val_q <= 1'b0;
            val_q <= 32'h0000_0000;
        end
        else if (vb & in_data)
        begin
            if (pos_q == hrf_pkg::OFF_TYPE)
                type_q <= vbyte;
            if (pos_q == hrf_pkg::OFF_ID)
                id_q <= vbyte;
            if (tx_kind & (pos_q >= hrf_pkg::OFF_DEST_FIRST) & (pos_q <= hrf_pkg::OFF_DEST_LAST))
                dest_q <= {dest_q[55:0], vbyte};
            if (is_leg & (pos_q == hrf_pkg::OFF_LEG_OPT))
                lopt_q <= vbyte;
            if (is_tx & (pos_q == hrf_pkg::OFF_HOPS))
                hops_q <= vbyte;
            if (is_tx & (pos_q == hrf_pkg::OFF_TX_OPT))
                txopt_q <= vbyte;
            if (is_par & (pos_q >= hrf_pkg::OFF_CMD_FIRST) & (pos_q <= hrf_pkg::OFF_CMD_LAST))
                cmd_q <= {cmd_q[7:0], vbyte};
            if (is_par & (pos_q >= hrf_pkg::OFF_VALUE))
            begin
                val_q <= {val_q[23:0], vbyte};
                has_val_q <= 1'b1;
            end
        end
    end

    // Transmit request results
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tx_done <= 1'b0;
            tx_ok <= 1'b0;
            tx_legacy <= 1'b0;
            tx_frame_id <= 8'h00;
            tx_dest <= 64'h0;
            tx_bcast <= 1'b0;
            tx_no_ack <= 1'b0;
            tx_opts <= 8'h00;
            tx_hops <= 8'h00;
        end
        else
        begin
            tx_done <= tx_end;
            tx_ok <= tx_end & good & ~over_q;
            if (tx_end & good)
            begin
                tx_legacy <= is_leg;
                tx_frame_id <= id_q;
                tx_dest <= dest_q;
                tx_bcast <= (dest_q == hrf_pkg::BCAST_ADDR);
                tx_no_ack <= is_leg & (lopt_q == hrf_pkg::LEG_OPT_NO_ACK);
                tx_opts <= is_leg ? 8'h00 : txopt_q;
                tx_hops <= (is_leg | (hops_q == 8'h00)) ?
                           par_act_q[hrf_pkg::PAR_HOPS] : hops_q;
            end
        end
    end

    // Response requests and error pulse
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            resp_valid <= 1'b0;
            resp_type <= 8'h00;
            resp_frame_id <= 8'h00;
            resp_value <= 32'h0000_0000;
            frame_err <= 1'b0;
        end
        else
        begin
            resp_valid <= good & (id_q != 8'h00);
            frame_err <= (fin & ~good) | (restart & ~idle);
            if (good & (id_q != 8'h00))
            begin
                resp_type <= tx_kind ? hrf_pkg::T_TX_STATUS : hrf_pkg::T_PARAM_RESP;
                resp_frame_id <= id_q;
                resp_value <= (is_par & ~has_val_q) ? rd_val : 32'h0000_0000;
            end
        end
    end
endmodule : hrf_frame_decoder

`default_nettype wire

// file: sim/hrf_host_model.sv
/*
 * Host model: frames request bytes onto the decoder's serial input.
 * Assumes the decoder samples on the rising edge of clk.
 */
`timescale 1ns/1ps
`default_nettype none

module hrf_host_model (
    input wire logic clk,
    input wire logic rx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid
);
    logic [7:0] q [$];
    logic took = 1'b0;
    int gap = 0;
    int wait_n = 0;

    initial rx_data = 8'h5a;
    initial rx_valid = 1'b0;

    // Note each byte that the decoder takes
    always @(posedge clk) took <= rx_valid && rx_ready;

    // Next byte after a take; an idle line toggles so no stale value shows
    always @(negedge clk)
    begin
        if (took || !rx_valid)
        begin
            if (q.size() > 0 && wait_n >= gap)
            begin
                rx_data <= q.pop_front();
                rx_valid <= 1'b1;
                wait_n <= 0;
            end
            else
            begin
                rx_data <= ~rx_data;
                rx_valid <= 1'b0;
                wait_n <= wait_n + 1;
            end
        end
    end

    // Queue one byte, escaped when asked
    task automatic put(input logic [7:0] b, input logic esc);
        if (esc && (b == 8'h7e || b == 8'h7d || b == 8'h11 || b == 8'h13))
        begin
            q.push_back(8'h7d);
            q.push_back(b ^ 8'h20);
        end
        else
            q.push_back(b);
    endtask : put

    // Whole frame: delimiter, length, data, checksum (bad flips bits)
    task automatic send(input logic [7:0] d [$], input logic esc, input logic [7:0] bad);
        logic [7:0] s;
        logic [15:0] n;
        s = 8'h00;
        n = 16'(d.size());
        q.push_back(8'h7e);
        put(n[15:8], esc);
        put(n[7:0], esc);
        foreach (d[i])
        begin
            put(d[i], esc);
            s = s + d[i];
        end
        put((8'hff - s) ^ bad, esc);
    endtask : send
endmodule : hrf_host_model

`default_nettype wire

// file: sim/hrf_frame_decoder_assertions.sv
/*
 * Port checker for the frame decoder, bound to every instance.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module hrf_frame_decoder_assertions (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] pay_data,
    input wire logic pay_last,
    input wire logic pay_valid,
    input wire logic pay_ready,
    input wire logic tx_done,
    input wire logic tx_ok,
    input wire logic [63:0] tx_dest,
    input wire logic tx_bcast,
    input wire logic resp_valid,
    input wire logic [7:0] resp_type,
    input wire logic [7:0] resp_frame_id,
    input wire logic frame_err,
    input wire logic [7:0] serial_rate_setting,
    input wire logic [7:0] network_hop_limit,
    input wire logic [7:0] api_escape_setting
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_ready_after_reset: assert property ($fell(sys_rst) |=> rx_ready)
        else $error("rx_ready low after reset");
    a_resp_one_cycle: assert property (resp_valid |=> !resp_valid)
        else $error("resp_valid longer than one cycle");
    a_resp_id_type: assert property (resp_valid |-> resp_frame_id != 8'h00 &&
        (resp_type == hrf_pkg::T_TX_STATUS || resp_type == hrf_pkg::T_PARAM_RESP))
        else $error("response with zero id or bad type");
    a_err_stays_quiet: assert property (frame_err |-> !resp_valid && !tx_ok)
        else $error("dropped frame still answered");
    a_ok_needs_done: assert property (tx_ok |-> tx_done)
        else $error("tx_ok without tx_done");
    a_status_after_tx: assert property (resp_valid &&
        resp_type == hrf_pkg::T_TX_STATUS |-> tx_done && tx_ok)
        else $error("transmit status without good frame");
    a_bcast_decode: assert property (tx_bcast == (tx_dest == hrf_pkg::BCAST_ADDR))
        else $error("broadcast flag disagrees with destination");
    a_pay_held: assert property (pay_valid && !pay_ready |=>
        pay_valid && $stable(pay_data) && $stable(pay_last))
        else $error("payload byte changed while stalled");
    a_pay_from_rx: assert property ($rose(pay_valid) && !$past(sys_rst) |->
        $past(rx_valid && rx_ready))
        else $error("payload appeared without a taken byte");
    a_settings_move: assert property ($changed({serial_rate_setting,
        network_hop_limit, api_escape_setting}) && !$past(sys_rst) |->
        $past(rx_valid && rx_ready))
        else $error("setting changed without a taken byte");
endmodule : hrf_frame_decoder_assertions

bind hrf_frame_decoder hrf_frame_decoder_assertions u_chk (.clk, .sys_rst, .rx_valid,
    .rx_ready, .pay_data, .pay_last, .pay_valid, .pay_ready, .tx_done, .tx_ok, .tx_dest,
    .tx_bcast, .resp_valid, .resp_type, .resp_frame_id, .frame_err, .serial_rate_setting,
    .network_hop_limit, .api_escape_setting);

`default_nettype wire

// file: sim/test_host_request_frame_decoder.sv
/*
 * Bench for the frame decoder: the host model sends frames, monitors count
 * result pulses and collect payload. Assumes package and model compile first.
 */
`timescale 1ns/1ps
`default_nettype none

module test_host_request_frame_decoder;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pay_ready = 1'b1;
    logic [7:0] rx_data, pay_data, tx_frame_id, tx_opts, tx_hops, resp_type, resp_frame_id;
    logic [7:0] serial_rate_setting, network_hop_limit, api_escape_setting;
    logic rx_valid, rx_ready, pay_last, pay_valid, tx_done, tx_ok, tx_legacy;
    logic tx_bcast, tx_no_ack, resp_valid, frame_err;
    logic [63:0] tx_dest;
    logic [31:0] resp_value;
    logic [8:0] pq [$];
    int n_fail = 0;
    int total_checks = 0;
    int n_resp, n_ok, n_err, cyc;

    hrf_frame_decoder DUT (.clk, .sys_rst, .rx_data, .rx_valid, .rx_ready, .pay_data,
        .pay_last, .pay_valid, .pay_ready, .tx_done, .tx_ok, .tx_legacy, .tx_frame_id,
        .tx_dest, .tx_bcast, .tx_no_ack, .tx_opts, .tx_hops, .resp_valid, .resp_type,
        .resp_frame_id, .resp_value, .frame_err, .serial_rate_setting, .network_hop_limit,
        .api_escape_setting);
    hrf_host_model host (.clk, .rx_ready, .rx_data, .rx_valid);

    initial forever #50 clk = ~clk;

    // Count pulses, collect payload, cut a hang short
    always @(posedge clk)
    begin
        n_resp += int'(resp_valid === 1'b1);
        n_ok += int'(tx_done === 1'b1 && tx_ok === 1'b1);
        n_err += int'(frame_err === 1'b1);
        if (pay_valid === 1'b1 && pay_ready)
            pq.push_back({pay_last, pay_data});
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            finish_test();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask : check

    task automatic start();
        n_resp = 0;
        n_ok = 0;
        n_err = 0;
        pq.delete();
    endtask : start

    task automatic flush();
        while (host.q.size() > 0 || rx_valid)
            @(negedge clk);
        repeat (4) @(negedge clk);
    endtask : flush

    task automatic pay_chk(input logic [7:0] e [$]);
        check(pq.size(), e.size());
        foreach (e[i])
            check(pq[i], {i == e.size() - 1, e[i]});
    endtask : pay_chk

    task automatic t_query();
        start();
        check(network_hop_limit, 8'h07);
        host.q.push_back(8'h33);
        host.send('{8'h08, 8'h52, 8'h4e, 8'h48}, 1'b0, 8'h00);
        flush();
        check(n_resp, 1);
        check(resp_type, 8'h88);
        check(resp_frame_id, 8'h52);
        check(resp_value, 32'h7);
        $display("test query done");
    endtask : t_query

    task automatic t_queue();
        start();
        host.send('{8'h09, 8'h01, 8'h42, 8'h44, 8'h07}, 1'b0, 8'h00);
        flush();
        check(serial_rate_setting, 8'h03);
        host.send('{8'h08, 8'h00, 8'h41, 8'h43}, 1'b0, 8'h00);
        flush();
        check(serial_rate_setting, 8'h07);
        check(n_resp, 1);
        host.send('{8'h08, 8'h03, 8'h4e, 8'h48, 8'h00, 8'h00, 8'h00, 8'h05}, 1'b0, 8'h00);
        flush();
        check(network_hop_limit, 8'h05);
        host.send('{8'h08, 8'h04, 8'h4e, 8'h50}, 1'b0, 8'h00);
        flush();
        check(resp_value, 32'(hrf_pkg::MAX_PAYLOAD));
        $display("test queue done");
    endtask : t_queue

    task automatic t_legacy();
        start();
        host.gap = 2;
        host.send('{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
            8'h01, 8'ha1, 8'ha2, 8'ha3}, 1'b0, 8'h00);
        flush();
        host.gap = 0;
        check(n_ok, 1);
        check(tx_legacy, 1'b1);
        check(tx_frame_id, 8'h01);
        check(tx_bcast, 1'b1);
        check(tx_no_ack, 1'b1);
        check(tx_hops, 8'h05);
        check(resp_type, 8'h8b);
        pay_chk('{8'ha1, 8'ha2, 8'ha3});
        $display("test legacy done");
    endtask : t_legacy

    task automatic t_tx();
        start();
        pay_ready = 1'b0;
        host.send('{8'h10, 8'h00, 8'h00, 8'h13, 8'ha2, 8'h00, 8'h40, 8'h0a, 8'h01, 8'h27,
            8'hff, 8'hfe, 8'h03, 8'h40, 8'h54, 8'h78, 8'h44, 8'h61}, 1'b0, 8'h00);
        repeat (30) @(negedge clk);
        check(rx_ready, 1'b0);
        check(pay_valid, 1'b1);
        pay_ready = 1'b1;
        flush();
        check(n_resp, 0);
        check(tx_dest, 64'h0013a200400a0127);
        check(tx_hops, 8'h03);
        check(tx_opts, 8'h40);
        check(tx_no_ack, 1'b0);
        pay_chk('{8'h54, 8'h78, 8'h44, 8'h61});
        host.send('{8'h10, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
            8'hff, 8'hfe, 8'h00, 8'h00}, 1'b0, 8'h00);
        flush();
        check(tx_hops, 8'h05);
        check(resp_frame_id, 8'h07);
        $display("test tx done");
    endtask : t_tx

    task automatic t_bad();
        start();
        host.send('{8'h08, 8'h01, 8'h4e, 8'h48}, 1'b0, 8'h01);
        host.send('{8'h55, 8'h01, 8'h4e, 8'h48}, 1'b0, 8'h00);
        host.send('{8'h08, 8'h01, 8'h4e}, 1'b0, 8'h00);
        host.send('{8'h08, 8'h09, 8'h4e, 8'h48}, 1'b0, 8'h00);
        flush();
        check(n_err, 3);
        check(n_resp, 1);
        check(resp_frame_id, 8'h09);
        $display("test bad done");
    endtask : t_bad

    task automatic t_esc();
        start();
        host.send('{8'h08, 8'h00, 8'h41, 8'h50, 8'h02}, 1'b0, 8'h00);
        flush();
        check(api_escape_setting, 8'h02);
        host.send('{8'h08, 8'h7d, 8'h4e, 8'h48}, 1'b1, 8'h00);
        host.send('{8'h08, 8'h00, 8'h41, 8'h50, 8'h01}, 1'b1, 8'h00);
        flush();
        check(resp_frame_id, 8'h7d);
        check(resp_value, 32'h5);
        check(api_escape_setting, 8'h01);
        $display("test escape done");
    endtask : t_esc

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // Reset for five cycles, then run scenarios
    initial
    begin
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        @(negedge clk);
        t_query();
        t_queue();
        t_legacy();
        t_tx();
        t_bad();
        t_esc();
        finish_test();
    end
endmodule : test_host_request_frame_decoder

`default_nettype wire
